// ### feam_consts.svh
`ifndef FEAM_CONSTS_SVH
`define FEAM_CONSTS_SVH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define FEAM_OP_WRITE_ENABLE_CMD 8'h06
`define FEAM_OP_BLK_ERASE_4B 8'hDC
`define FEAM_OP_CHIP_ERASE_A 8'hC7
`define FEAM_OP_CHIP_ERASE_B 8'h60
`define FEAM_OP_ENTER_4B 8'hB7
`define FEAM_OP_EXIT_4B 8'hE9
`define FEAM_OP_READ_EXT 8'hC8
`define FEAM_OP_WRITE_EXT 8'hC5
`define FEAM_OP_ENTER_QPI 8'h38
`define FEAM_OP_EXIT_QPI 8'hFF
`define FEAM_OP_READ_STATUS 8'h05
// ----------------------------------------
// Status layout, reset value and erased byte
// ----------------------------------------
`define FEAM_SR_WIP_BIT 0
`define FEAM_SR_WEL_BIT 1
`define FEAM_EXT_RESET 8'h00
`define FEAM_ERASED_BYTE 8'hFF
// ----------------------------------------
// Timing: erase times in microseconds
// ----------------------------------------
`define FEAM_CLK_MHZ 50
`define FEAM_T_BE_US 300000
`define FEAM_T_CE_US 120000000
`define FEAM_BE_CYCLES (64'd`FEAM_T_BE_US * 64'd`FEAM_CLK_MHZ)
`define FEAM_CE_CYCLES (64'd`FEAM_T_CE_US * 64'd`FEAM_CLK_MHZ)
`endif

// ### feam_pkg.sv
package feam_pkg;
  // Serial front end states, Gray-coded in listed order
  typedef enum logic [2:0] {
    FEAM_IDLE = 3'b000,
    FEAM_OPC = 3'b001,
    FEAM_ADDR = 3'b011,
    FEAM_DATA = 3'b010,
    FEAM_READ = 3'b110,
    FEAM_SKIP = 3'b111
  } feam_state_t;
  // Erase engine states
  typedef enum logic [1:0] {
    FEAM_E_IDLE = 2'b00,
    FEAM_E_BUSY = 2'b01,
    FEAM_E_DONE = 2'b11
  } feam_erase_t;
endpackage

// ### feam_sync.sv
`timescale 1ns/1ps
module feam_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  // Two-stage synchroniser; stage1 is read only by stage2
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
    end
  end
  assign sync_o = stage2;
endmodule

// ### feam_erase_timer.sv
`timescale 1ns/1ps
`include "feam_consts.svh"
module feam_erase_timer #(
  parameter logic [63:0] BE_CYCLES = `FEAM_BE_CYCLES,
  parameter logic [63:0] CE_CYCLES = `FEAM_CE_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic start_block_i,
  input wire logic start_chip_i,
  output logic busy_o,
  output logic done_o
);
  feam_pkg::feam_erase_t state;
  feam_pkg::feam_erase_t next_state;
  logic [63:0] count;
  logic [63:0] next_count;
  // Self-timed cycle; starts while busy are dropped so a run is never disturbed
  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      feam_pkg::FEAM_E_IDLE: begin
        if (start_block_i) begin
          next_count = BE_CYCLES - 64'd1;
          next_state = feam_pkg::FEAM_E_BUSY;
        end else if (start_chip_i) begin
          next_count = CE_CYCLES - 64'd1;
          next_state = feam_pkg::FEAM_E_BUSY;
        end
      end
      feam_pkg::FEAM_E_BUSY: begin
        if (count == 64'd0) begin
          next_state = feam_pkg::FEAM_E_DONE;
        end else begin
          next_count = count - 64'd1;
        end
      end
      feam_pkg::FEAM_E_DONE: next_state = feam_pkg::FEAM_E_IDLE;
      default: next_state = feam_pkg::FEAM_E_IDLE;
    endcase
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state <= feam_pkg::FEAM_E_IDLE;
      count <= 64'd0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end
  assign busy_o = (state != feam_pkg::FEAM_E_IDLE);
  assign done_o = (state == feam_pkg::FEAM_E_DONE);
endmodule

// ### feam_ctrl.sv
`timescale 1ns/1ps
`include "feam_consts.svh"
// Overview of operation
// - Wide-address block erase opcode erases the addressed 64KB block to all ones.
// - Write enable sets the latch; erases are accepted only while it is set.
// - Any address inside a 64KB block selects that block.
// - Block erase runs only if select rises right after the last address bit.
// - Valid block erase starts a self-timed cycle of the block erase time.
// - Write-in-progress reads one during the cycle and zero after; status readable.
// - Write-enable latch is cleared as the erase cycle finishes, in the same cycle write-in-progress falls.
// - Block erase to a protected block is not carried out.
// - Either chip erase opcode erases the whole array to all ones.
// - Chip erase is opcode only and runs only if select rises after bit eight.
// - Chip erase runs a self-timed cycle holding write-in-progress high.
// - Chip erase is ignored while any block is protected.
// - Commands are also taken in quad mode, four lines per clock.
// - Device starts in 24-bit addressing; enter opcode sets the wide-address flag.
// - In wide mode every instruction works as usual, only address length differs; here block erase takes four address bytes in either mode.
// - Exit opcode clears the wide-address flag and restores 24-bit addressing.
// - In 3-byte mode address bits 31 to 24 come from the extended register; here block erase takes them from its own four address bytes.
// - Extended register read shifts its value out on falling edges, MSB first.
// - In wide mode the extended register plays no part in address formation.
// - Extended register is volatile and cleared at reset.
// - Extended register write takes one data byte, only with the latch set.
module feam_ctrl #(
  parameter logic [63:0] BE_CYCLES = `FEAM_BE_CYCLES,
  parameter logic [63:0] CE_CYCLES = `FEAM_CE_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic spi_clk_i,
  input wire logic spi_cs_n_i,
  input wire logic [3:0] dq_i,
  output logic [3:0] dq_o,
  output logic [3:0] dq_oe_o,
  input wire logic protect_complement_i,
  input wire logic protect_top_bottom_i,
  input wire logic [3:0] protect_level_i,
  input wire logic block_protected_i,
  input wire logic any_protected_i,
  output logic [8:0] protect_query_block_o,
  output logic write_in_progress_o,
  output logic write_enable_latch_o,
  output logic wide_address_flag_o,
  output logic quad_peripheral_mode_o,
  output logic [7:0] ext_addr_o,
  output logic erase_block_o,
  output logic [31:0] erase_addr_o,
  output logic erase_chip_o,
  output logic [7:0] erase_fill_o
);
  // ----------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------
  logic [5:0] pins_s;
  logic sclk_d;
  logic cs_d;
  feam_sync #(.WIDTH(6)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({spi_clk_i, ~spi_cs_n_i, dq_i}),
    .sync_o(pins_s)
  );
  logic sclk_s;
  logic cs_s;
  logic [3:0] dq_s;
  assign sclk_s = pins_s[5];
  // Select travels inverted so the cleared stages read as deselected, no false edge
  assign cs_s = ~pins_s[4];
  assign dq_s = pins_s[3:0];
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic cs_fall;
  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;
  assign cs_rise = cs_s & ~cs_d;
  assign cs_fall = ~cs_s & cs_d;
  // ----------------------------------------
  // Front end state
  // ----------------------------------------
  feam_pkg::feam_state_t state;
  feam_pkg::feam_state_t next_state;
  logic [7:0] opcode;
  logic [7:0] next_opcode;
  logic [31:0] shreg;
  logic [31:0] next_shreg;
  logic [5:0] bits;
  logic [5:0] next_bits;
  logic [7:0] tx;
  logic [7:0] next_tx;
  logic [3:0] dq_out;
  logic [3:0] next_dq_out;
  logic drive;
  logic next_drive;
  logic write_enable_latch;
  logic next_wel;
  logic wide;
  logic next_wide;
  logic qpi;
  logic next_qpi;
  logic [7:0] ext;
  logic [7:0] next_ext;
  logic start_block;
  logic start_chip;
  logic [31:0] erase_addr;
  logic [31:0] next_erase_addr;
  logic busy;
  logic done;
  logic [5:0] step;
  logic [5:0] addr_bits;
  logic [7:0] rx_byte;
  logic [31:0] full_addr;
  logic [31:0] shifted;
  assign step = qpi ? 6'd4 : 6'd1;
  assign addr_bits = wide ? 6'd32 : 6'd24;
  assign shifted = qpi ? {shreg[27:0], dq_s} : {shreg[30:0], dq_s[0]};
  assign rx_byte = shifted[7:0];
  // Extended byte fills the top only for 3-byte forms; the wide erase carries its own
  logic own_top;
  assign own_top = wide || (state == feam_pkg::FEAM_ADDR);
  assign full_addr = own_top ? shreg : {ext, shreg[23:0]};
  // Block number is address bits 24:16; low bits are don't-care
  assign protect_query_block_o = full_addr[24:16];
  // Decode the command on bits, then act on the select edge
  always_comb begin
    next_state = state;
    next_opcode = opcode;
    next_shreg = shreg;
    next_bits = bits;
    next_tx = tx;
    next_dq_out = dq_out;
    next_drive = drive;
    next_wel = write_enable_latch;
    next_wide = wide;
    next_qpi = qpi;
    next_ext = ext;
    next_erase_addr = erase_addr;
    start_block = 1'b0;
    start_chip = 1'b0;
    if (done) begin
      next_wel = 1'b0;
    end
    if (cs_s) begin
      next_drive = 1'b0;
      if (cs_rise) begin
        case (state)
          feam_pkg::FEAM_OPC: begin
            // Opcode-only commands need exactly eight bits
            if (bits == 6'd8) begin
              case (opcode)
                `FEAM_OP_WRITE_ENABLE_CMD: if (!busy) next_wel = 1'b1;
                `FEAM_OP_ENTER_4B: if (!busy) next_wide = 1'b1;
                `FEAM_OP_EXIT_4B: if (!busy) next_wide = 1'b0;
                `FEAM_OP_ENTER_QPI: if (!busy) next_qpi = 1'b1;
                `FEAM_OP_EXIT_QPI: if (!busy && qpi) next_qpi = 1'b0;
                `FEAM_OP_CHIP_ERASE_A, `FEAM_OP_CHIP_ERASE_B: begin
                  if (write_enable_latch && !busy && !any_protected_i) begin
                    start_chip = 1'b1;
                  end
                end
                default: ;
              endcase
            end
          end
          feam_pkg::FEAM_ADDR: begin
            // Block erase always carries four bytes; abort on any other count
            if (bits == 6'd32 && write_enable_latch && !busy && !block_protected_i) begin
              start_block = 1'b1;
              next_erase_addr = {shreg[31:16], 16'h0000};
            end
          end
          feam_pkg::FEAM_DATA: begin
            if (bits == 6'd8 && write_enable_latch && !busy) begin
              next_ext = shreg[7:0];
              next_wel = 1'b0;
            end
          end
          default: ;
        endcase
      end
      next_state = feam_pkg::FEAM_IDLE;
    end else if (cs_fall || state == feam_pkg::FEAM_IDLE) begin
      next_state = feam_pkg::FEAM_OPC;
      next_bits = 6'd0;
      next_shreg = 32'h0000_0000;
    end else if (sclk_rise) begin
      case (state)
        feam_pkg::FEAM_OPC: begin
          next_bits = bits + step;
          next_shreg = shifted;
          if (bits + step == 6'd8) begin
            next_opcode = rx_byte;
            next_bits = 6'd8;
            if (rx_byte == `FEAM_OP_BLK_ERASE_4B) begin
              next_state = feam_pkg::FEAM_ADDR;
              next_bits = 6'd0;
            end else if (rx_byte == `FEAM_OP_WRITE_EXT) begin
              next_state = feam_pkg::FEAM_DATA;
              next_bits = 6'd0;
            end else if (rx_byte == `FEAM_OP_READ_EXT) begin
              next_state = feam_pkg::FEAM_READ;
              next_tx = ext;
            end else if (rx_byte == `FEAM_OP_READ_STATUS) begin
              next_state = feam_pkg::FEAM_READ;
              next_tx = {6'b000000, write_enable_latch, busy};
            end
          end else if (bits + step > 6'd8) begin
            next_state = feam_pkg::FEAM_SKIP;
          end
        end
        feam_pkg::FEAM_ADDR, feam_pkg::FEAM_DATA: begin
          next_shreg = shifted;
          next_bits = (bits == 6'd63) ? bits : bits + step;
        end
        default: ;
      endcase
    end else if (sclk_fall && state == feam_pkg::FEAM_READ) begin
      // MSB first on falling edges, register repeats
      next_drive = 1'b1;
      if (qpi) begin
        next_dq_out = tx[7:4];
        next_tx = {tx[3:0], tx[7:4]};
      end else begin
        next_dq_out = {2'b00, tx[7], 1'b0};
        next_tx = {tx[6:0], tx[7]};
      end
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state <= feam_pkg::FEAM_IDLE;
      opcode <= 8'h00;
      shreg <= 32'h0000_0000;
      bits <= 6'd0;
      tx <= 8'h00;
      dq_out <= 4'h0;
      drive <= 1'b0;
      write_enable_latch <= 1'b0;
      wide <= 1'b0;
      qpi <= 1'b0;
      ext <= `FEAM_EXT_RESET;
      erase_addr <= 32'h0000_0000;
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      state <= next_state;
      opcode <= next_opcode;
      shreg <= next_shreg;
      bits <= next_bits;
      tx <= next_tx;
      dq_out <= next_dq_out;
      drive <= next_drive;
      write_enable_latch <= next_wel;
      wide <= next_wide;
      qpi <= next_qpi;
      ext <= next_ext;
      erase_addr <= next_erase_addr;
      sclk_d <= sclk_s;
      cs_d <= cs_s;
    end
  end
  // ----------------------------------------
  // Erase timing
  // ----------------------------------------
  feam_erase_timer #(.BE_CYCLES(BE_CYCLES), .CE_CYCLES(CE_CYCLES)) u_timer (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .start_block_i(start_block),
    .start_chip_i(start_chip),
    .busy_o(busy),
    .done_o(done)
  );
  // Array side pulses; fill pattern is constant all ones
  logic erase_block_q;
  logic erase_chip_q;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      erase_block_q <= 1'b0;
      erase_chip_q <= 1'b0;
    end else begin
      erase_block_q <= start_block;
      erase_chip_q <= start_chip;
    end
  end
  // Protect bits are decoded outside; kept visible for the table logic
  logic unused_protect;
  assign unused_protect = protect_complement_i ^ protect_top_bottom_i ^ (^protect_level_i);
  assign erase_block_o = erase_block_q;
  assign erase_chip_o = erase_chip_q;
  assign erase_addr_o = erase_addr;
  assign erase_fill_o = `FEAM_ERASED_BYTE;
  assign write_in_progress_o = busy;
  assign write_enable_latch_o = write_enable_latch;
  assign wide_address_flag_o = wide;
  assign quad_peripheral_mode_o = qpi;
  assign ext_addr_o = ext;
  assign dq_o = dq_out;
  assign dq_oe_o = drive ? (qpi ? 4'hF : 4'h2) : 4'h0;
endmodule

// ### feam_chk_sva.sv
`timescale 1ns/1ps
module feam_chk #(
  parameter logic [63:0] BE_CYCLES = 64'h14,
  parameter logic [63:0] CE_CYCLES = 64'h28
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] dq_oe_o,
  input wire logic any_protected_i,
  input wire logic write_in_progress_o,
  input wire logic write_enable_latch_o,
  input wire logic quad_peripheral_mode_o,
  input wire logic erase_block_o,
  input wire logic [31:0] erase_addr_o,
  input wire logic erase_chip_o,
  input wire logic [7:0] erase_fill_o
);
  logic [63:0] wip_cnt;
  logic [63:0] next_wip_cnt;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Length of the current busy stretch; too long for a repetition
  always_comb begin
    next_wip_cnt = write_in_progress_o ? wip_cnt + 64'h1 : 64'h0;
  end
  always_ff @(posedge core_clk_i) begin
    wip_cnt <= rst_n_i ? next_wip_cnt : 64'h0;
  end
  // ----------------------------------------
  // Erase and read-lane checks
  // ----------------------------------------
  property p_fill;
    erase_fill_o == 8'hFF;
  endproperty
  a_fill: assert property (p_fill) else $error("fill byte wrong");
  property p_wel;
    (erase_block_o || erase_chip_o) |-> write_enable_latch_o;
  endproperty
  a_wel: assert property (p_wel) else $error("erase without latch");
  property p_base;
    erase_block_o |-> erase_addr_o[15:0] == 16'h0000;
  endproperty
  a_base: assert property (p_base) else $error("block base not aligned");
  property p_start;
    erase_block_o |-> write_in_progress_o && !$past(write_in_progress_o);
  endproperty
  a_start: assert property (p_start) else $error("erase without busy");
  property p_len;
    $fell(write_in_progress_o) |->
      (wip_cnt == BE_CYCLES + 64'h1) || (wip_cnt == CE_CYCLES + 64'h1);
  endproperty
  a_len: assert property (p_len) else $error("busy length wrong");
  property p_clr;
    $fell(write_in_progress_o) |-> ##[0:1] !write_enable_latch_o;
  endproperty
  a_clr: assert property (p_clr) else $error("latch not cleared");
  property p_prot;
    erase_chip_o |-> !any_protected_i;
  endproperty
  a_prot: assert property (p_prot) else $error("chip erase while protected");
  property p_busy;
    (erase_block_o || erase_chip_o) |-> !$past(write_in_progress_o, 2);
  endproperty
  a_busy: assert property (p_busy) else $error("erase during busy");
  property p_oe;
    dq_oe_o != 4'h0 |-> dq_oe_o == (quad_peripheral_mode_o ? 4'hF : 4'h2);
  endproperty
  a_oe: assert property (p_oe) else $error("read lanes wrong");
  c_blk: cover property (erase_block_o);
  c_chip: cover property (erase_chip_o);
  c_read: cover property (dq_oe_o == 4'h2);
  c_qread: cover property (dq_oe_o == 4'hF);
endmodule
bind feam_ctrl feam_chk #(.BE_CYCLES(BE_CYCLES), .CE_CYCLES(CE_CYCLES)) u_feam_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .dq_oe_o(dq_oe_o),
  .any_protected_i(any_protected_i), .write_in_progress_o(write_in_progress_o),
  .write_enable_latch_o(write_enable_latch_o), .erase_fill_o(erase_fill_o),
  .quad_peripheral_mode_o(quad_peripheral_mode_o), .erase_block_o(erase_block_o),
  .erase_addr_o(erase_addr_o), .erase_chip_o(erase_chip_o));

// ### feam_host.sv
`timescale 1ns/1ps
module feam_host (
  input wire logic core_clk_i,
  input wire logic [3:0] dq_o,
  output logic spi_clk_o,
  output logic spi_cs_n_o,
  output logic [3:0] dq_drv_o,
  output logic [7:0] rd_o
);
  // Idle: deselected, clock parked low
  initial begin
    spi_clk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    dq_drv_o = 4'hA;
    rd_o = 8'h00;
  end
  // ----------------------------------------
  // One framed transfer, MSB first
  // ----------------------------------------
  // Sampled at each rise; the last byte taken is the answer of a read
  task automatic xfer(input logic [47:0] v, input int n, input bit q);
    int w;
    w = q ? 4 : 1;
    @(posedge core_clk_i);
    spi_cs_n_o <= 1'b0;
    for (int i = n; i > 0; i -= w) begin
      @(posedge core_clk_i);
      dq_drv_o <= q ? v[i-1 -: 4] : {~dq_drv_o[3:1], v[i-1]};
      repeat (3) @(posedge core_clk_i);
      spi_clk_o <= 1'b1;
      rd_o <= q ? {rd_o[3:0], dq_o} : {rd_o[6:0], dq_o[1]};
      repeat (4) @(posedge core_clk_i);
      spi_clk_o <= 1'b0;
    end
    repeat (4) @(posedge core_clk_i);
    spi_cs_n_o <= 1'b1;
    // Released lines must not keep their last level
    dq_drv_o <= ~dq_drv_o;
    repeat (6) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
`include "feam_consts.svh"
module tb_top;
  logic core_clk_i, rst_n_i, spi_clk_i, spi_cs_n_i, erase_block_o, erase_chip_o;
  logic write_in_progress_o, write_enable_latch_o, wide_address_flag_o;
  logic quad_peripheral_mode_o, block_protected_i, any_protected_i, qm;
  logic [3:0] dq_i, dq_o, dq_oe_o, protect_level_i;
  logic [7:0] ext_addr_o, erase_fill_o, rd;
  logic [8:0] protect_query_block_o;
  logic [31:0] erase_addr_o, eaddr;
  int num_errors = 0;
  int checked = 0;
  int nblk = 0;
  int nchip = 0;
  feam_ctrl #(.BE_CYCLES(64'd1000), .CE_CYCLES(64'd1500)) u_feam_ctrl (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .spi_clk_i(spi_clk_i),
    .spi_cs_n_i(spi_cs_n_i), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .protect_complement_i(1'b0), .protect_top_bottom_i(1'b0),
    .protect_level_i(protect_level_i), .block_protected_i(block_protected_i),
    .any_protected_i(any_protected_i), .protect_query_block_o(protect_query_block_o),
    .write_in_progress_o(write_in_progress_o), .write_enable_latch_o(write_enable_latch_o),
    .wide_address_flag_o(wide_address_flag_o), .ext_addr_o(ext_addr_o),
    .quad_peripheral_mode_o(quad_peripheral_mode_o), .erase_block_o(erase_block_o),
    .erase_addr_o(erase_addr_o), .erase_chip_o(erase_chip_o), .erase_fill_o(erase_fill_o));
  feam_host u_feam_host (.core_clk_i(core_clk_i), .dq_o(dq_o), .spi_clk_o(spi_clk_i),
    .spi_cs_n_o(spi_cs_n_i), .dq_drv_o(dq_i), .rd_o(rd));
  // Protect decode stand-in: any level guards the top block only
  assign any_protected_i = (protect_level_i != 4'h0);
  assign block_protected_i = any_protected_i && (protect_query_block_o == 9'h1FF);
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  // Pulses counted away from the active edge
  always @(negedge core_clk_i) begin
    if (erase_block_o === 1'b1) begin
      nblk++;
      eaddr = erase_addr_o;
    end
    if (erase_chip_o === 1'b1) nchip++;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    u_feam_host.xfer({40'h0, op}, 8, qm);
  endtask
  task automatic two(input logic [7:0] op, input logic [7:0] d);
    u_feam_host.xfer({32'h0, op, d}, 16, qm);
  endtask
  task automatic blk(input logic [31:0] a, input int n);
    u_feam_host.xfer({`FEAM_OP_BLK_ERASE_4B, a, 8'h00} >> (48 - n), n, qm);
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    while (write_in_progress_o !== 1'b0 && k < 3000) begin
      @(negedge core_clk_i);
      k++;
    end
    if (k == 3000) begin
      num_errors++;
      print_verdict;
    end
  endtask
  task automatic reset_dut;
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n_i = 1'b0;
    protect_level_i = 4'h0;
    qm = 1'b0;
    reset_dut;
    chk("reset", 32'h0, {ext_addr_o, wide_address_flag_o, quad_peripheral_mode_o,
      write_enable_latch_o, write_in_progress_o});
    blk(32'h0123_4567, 40);
    chk("no latch", 0, nblk);
    cmd(`FEAM_OP_WRITE_ENABLE_CMD);
    chk("latch", 1, write_enable_latch_o);
    blk(32'h0123_4567, 40);
    two(`FEAM_OP_READ_STATUS, 8'h00);
    chk("busy status", 1, rd[0]);
    blk(32'h0200_0000, 40);
    wait_idle;
    chk("block pulses", 1, nblk);
    chk("block base", 32'h0123_0000, eaddr);
    chk("latch cleared", 0, write_enable_latch_o);
    // Short, long, unframed chip, protected block, protected chip
    for (int i = 0; i < 5; i++) begin
      cmd(`FEAM_OP_WRITE_ENABLE_CMD);
      @(posedge core_clk_i);
      protect_level_i <= (i > 2) ? 4'h1 : 4'h0;
      if (i < 2) blk(32'h0456_0000, 39 + 2 * i);
      else if (i == 2) u_feam_host.xfer({`FEAM_OP_CHIP_ERASE_B, 1'b0}, 9, qm);
      else if (i == 3) blk(32'h01FF_8000, 40);
      else cmd(`FEAM_OP_CHIP_ERASE_A);
    end
    @(posedge core_clk_i);
    protect_level_i <= 4'h0;
    chk("refused", 32'h1, nblk + nchip * 16);
    for (int k = 0; k < 2; k++) begin
      cmd(`FEAM_OP_WRITE_ENABLE_CMD);
      cmd(k == 0 ? `FEAM_OP_CHIP_ERASE_A : `FEAM_OP_CHIP_ERASE_B);
      chk("chip busy", 1, write_in_progress_o);
      wait_idle;
      chk("chip pulses", k + 1, nchip);
    end
    cmd(`FEAM_OP_ENTER_4B);
    chk("wide on", 1, wide_address_flag_o);
    cmd(`FEAM_OP_WRITE_ENABLE_CMD);
    blk(32'h0345_FFFF, 40);
    wait_idle;
    chk("wide base", 32'h0345_0000, eaddr);
    cmd(`FEAM_OP_EXIT_4B);
    chk("wide off", 0, wide_address_flag_o);
    two(`FEAM_OP_WRITE_EXT, 8'hA5);
    chk("ext locked", 0, ext_addr_o);
    cmd(`FEAM_OP_WRITE_ENABLE_CMD);
    two(`FEAM_OP_WRITE_EXT, 8'hA5);
    chk("ext", 8'hA5, ext_addr_o);
    two(`FEAM_OP_READ_EXT, 8'h00);
    chk("ext read", 8'hA5, rd);
    cmd(`FEAM_OP_ENTER_QPI);
    chk("quad on", 1, quad_peripheral_mode_o);
    qm = 1'b1;
    cmd(`FEAM_OP_WRITE_ENABLE_CMD);
    blk(32'h0200_8000, 40);
    two(`FEAM_OP_READ_STATUS, 8'h00);
    chk("quad status", 8'h03, rd);
    wait_idle;
    chk("quad base", 32'h0200_0000, eaddr);
    cmd(`FEAM_OP_EXIT_QPI);
    qm = 1'b0;
    chk("quad off", 0, quad_peripheral_mode_o);
    reset_dut;
    chk("ext cleared", 0, ext_addr_o);
    print_verdict;
  end
endmodule
